// ==== design/vc0_ctrl_pkg.sv ====
// Constants for the channel 0 resource control and status register bank
package vc0_ctrl_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [11:0] CAP_OFFSET = 12'h150;
  localparam logic [11:0] CTRL_OFFSET = 12'h154;
  localparam logic [11:0] STAT_OFFSET = 12'h158;
  localparam logic [11:0] IRQ_STAT_OFFSET = 12'h180;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h184;
  // ==========================================================
  // Control register fields
  localparam int MAP_LSB = 0;
  localparam int LOAD_BIT = 16;
  localparam int SEL_LSB = 17;
  localparam int ID_LSB = 24;
  localparam int ENABLE_BIT = 31;
  localparam logic [7:0] MAP_RESET = 8'hFF;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [2:0] SEL_ALT = 3'h3;
  localparam logic [2:0] CHANNEL_ID = 3'h0;
  localparam logic ENABLE_RESET = 1'b1;
  // ==========================================================
  // Status and capability fields
  localparam int TABLE_STAT_BIT = 16;
  localparam int NEG_PEND_BIT = 17;
  localparam int TABLE_OFS_LSB = 24;
  localparam logic [7:0] TABLE_OFS_RESET = 8'h04;
  // ==========================================================
  // Interrupt status bits
  localparam int IRQ_WIDTH = 3;
  localparam int IRQ_LOAD_DONE = 0;
  localparam int IRQ_NEG_DONE = 1;
  localparam int IRQ_TABLE_WR = 2;
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 3'h0;
  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic {LOAD_IDLE, LOAD_WAIT} load_state_t;
endpackage

// ==== design/reg_access_if.sv ====
// Register access carrier between the bus slave and the register bank
`timescale 1ns/1ps
interface reg_access_if;
  logic wrEn;
  logic [11:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrHit;
  logic [11:0] rdAddr;
  logic [31:0] rdData;
  logic rdHit;
  // ==========================================================
  // Bus side issues accesses, register side answers
  modport bus (output wrEn, output wrAddr, output wrData, output wrStrb, input wrHit,
               output rdAddr, input rdData, input rdHit);
  modport regs (input wrEn, input wrAddr, input wrData, input wrStrb, output wrHit,
                input rdAddr, output rdData, output rdHit);
endinterface

// ==== design/axil_slave.sv ====
// AXI4-Lite slave front end that turns bus transfers into register accesses
`timescale 1ns/1ps
module axil_slave (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [11:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte enables
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [11:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read response valid
  input wire logic rready, // Read response ready
  reg_access_if.bus acc // Register access carrier
);
  logic awHeld_reg;
  logic wHeld_reg;
  logic [11:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  // ==========================================================
  // Write channels: address and data taken in either order
  assign awready = !awHeld_reg && !bvalid;
  assign wready = !wHeld_reg && !bvalid;
  assign acc.wrEn = awHeld_reg && wHeld_reg && !bvalid;
  assign acc.wrAddr = awAddr_reg;
  assign acc.wrData = wData_reg;
  assign acc.wrStrb = wStrb_reg;

  // Capture address and data, release both once the write lands
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 12'h000;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (acc.wrEn) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
      end
    end
  end

  // Write response, held until the master takes it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= vc0_ctrl_pkg::RESP_OKAY;
    end else if (acc.wrEn) begin
      bvalid <= 1'b1;
      bresp <= acc.wrHit ? vc0_ctrl_pkg::RESP_OKAY : vc0_ctrl_pkg::RESP_DECERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Read channel: reads have no side effects, so data is taken at once
  assign arready = !rvalid;
  assign acc.rdAddr = araddr;

  // Read data registered on the same edge that takes the address
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= vc0_ctrl_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= acc.rdHit ? acc.rdData : 32'h00000000;
      rresp <= acc.rdHit ? vc0_ctrl_pkg::RESP_OKAY : vc0_ctrl_pkg::RESP_DECERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// ==== design/vc0_resource_control_status.sv ====
// Channel 0 resource control and status registers with AXI4-Lite access
//
// What this block does
// R1 - An 8-bit class-to-channel map, one bit per traffic class, resets to all ones.
// R2 - A map value fetched during serial EEPROM autoload replaces the map's reset default.
// R3 - Writing one to the table load bit starts a transfer of the table into live hardware.
// R4 - The table load bit always reads back as zero.
// R5 - The 3-bit scheme selector keeps only the two legal codes, anything else becomes default.
// R6 - A 3-bit read-only channel identifier reads as zero.
// R7 - The top control bit enables the channel when one, disables it when zero, reset one.
// R8 - Any software write to an arbitration table entry sets the table-status flag.
// R9 - The table-status flag clears only when a requested table load has finished.
// R10 - The negotiation-pending flag is set while negotiation runs and clears when it ends.
// R11 - The table location reads as offset 04h in 16-byte units from the capability base.
// R12 - Reserved bits read as zero and writes to them have no effect.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module vc0_resource_control_status (
  input wire logic ref_clk, // System clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [11:0] awaddr, // AXI write address
  input wire logic awvalid, // AXI write address valid
  output logic awready, // AXI write address ready
  input wire logic [31:0] wdata, // AXI write data
  input wire logic [3:0] wstrb, // AXI write byte enables
  input wire logic wvalid, // AXI write data valid
  output logic wready, // AXI write data ready
  output logic [1:0] bresp, // AXI write response
  output logic bvalid, // AXI write response valid
  input wire logic bready, // AXI write response ready
  input wire logic [11:0] araddr, // AXI read address
  input wire logic arvalid, // AXI read address valid
  output logic arready, // AXI read address ready
  output logic [31:0] rdata, // AXI read data
  output logic [1:0] rresp, // AXI read response
  output logic rvalid, // AXI read response valid
  input wire logic rready, // AXI read response ready
  input wire logic eepromMapValid, // Autoload map value strobe
  input wire logic [7:0] eepromMapData, // Autoload map value
  input wire logic tableEntryWrite, // Software wrote a table entry
  input wire logic tableLoadDone, // Arbiter finished loading the table
  input wire logic negotiationBusy, // Channel negotiation in progress
  output logic [7:0] classToChannelMap, // Classes mapped to this channel
  output logic [2:0] arbSchemeSelect, // Active arbitration scheme
  output logic channelEnable, // Channel enabled
  output logic tableLoadStart, // One-cycle table load request
  output logic irq // Level interrupt
);
  reg_access_if acc ();

  logic [7:0] map_reg;
  logic [2:0] select_reg;
  logic enable_reg;
  logic loadStart_reg;
  logic tableStatus_reg;
  logic tableStatus_next;
  logic negPending_reg;
  logic [vc0_ctrl_pkg::IRQ_WIDTH-1:0] irqStatus_reg;
  logic [vc0_ctrl_pkg::IRQ_WIDTH-1:0] irqStatus_next;
  logic [vc0_ctrl_pkg::IRQ_WIDTH-1:0] irqMask_reg;
  logic [vc0_ctrl_pkg::IRQ_WIDTH-1:0] irqEvents;
  vc0_ctrl_pkg::load_state_t loadState_reg;
  logic ctrlWrite;
  logic loadRequest;
  logic loadFinish;
  logic negComplete;

  // ==========================================================
  // Helper functions
  // Illegal scheme codes collapse to the default
  function automatic logic [2:0] legalScheme(input logic [2:0] code);
    legalScheme = (code == vc0_ctrl_pkg::SEL_ALT) ? vc0_ctrl_pkg::SEL_ALT
                                                  : vc0_ctrl_pkg::SEL_RESET;
  endfunction

  // Write-one-to-clear on the low bits, masked by byte lane 0
  function automatic logic [vc0_ctrl_pkg::IRQ_WIDTH-1:0] lowField(
    input logic [31:0] data,
    input logic [3:0] strb
  );
    lowField = strb[0] ? data[vc0_ctrl_pkg::IRQ_WIDTH-1:0] : '0;
  endfunction

  // ==========================================================
  // Bus front end
  axil_slave u_axil_slave (
    .ref_clk(ref_clk),
    .rst(rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .acc(acc.bus)
  );

  // ==========================================================
  // Address decode
  assign ctrlWrite = acc.wrEn && (acc.wrAddr == vc0_ctrl_pkg::CTRL_OFFSET);
  assign acc.wrHit = (acc.wrAddr == vc0_ctrl_pkg::CAP_OFFSET) ||
                     (acc.wrAddr == vc0_ctrl_pkg::CTRL_OFFSET) ||
                     (acc.wrAddr == vc0_ctrl_pkg::STAT_OFFSET) ||
                     (acc.wrAddr == vc0_ctrl_pkg::IRQ_STAT_OFFSET) ||
                     (acc.wrAddr == vc0_ctrl_pkg::IRQ_MASK_OFFSET);

  // ==========================================================
  // Class-to-channel map
  // Software write wins over an autoload arriving in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      map_reg <= vc0_ctrl_pkg::MAP_RESET; // [R1]
    end else if (ctrlWrite && acc.wrStrb[0]) begin
      map_reg <= acc.wrData[vc0_ctrl_pkg::MAP_LSB +: 8]; // [R1]
    end else if (eepromMapValid) begin
      map_reg <= eepromMapData; // [R2]
    end
  end

  // Scheme selector and channel enable, each on its own byte lane
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      select_reg <= vc0_ctrl_pkg::SEL_RESET;
      enable_reg <= vc0_ctrl_pkg::ENABLE_RESET;
    end else if (ctrlWrite) begin
      if (acc.wrStrb[2]) begin
        select_reg <= legalScheme(acc.wrData[vc0_ctrl_pkg::SEL_LSB +: 3]); // [R5]
      end
      if (acc.wrStrb[3]) begin
        enable_reg <= acc.wrData[vc0_ctrl_pkg::ENABLE_BIT]; // [R7]
      end
    end
  end

  // ==========================================================
  // Table load sequencing
  // A second request during a load is dropped; the first load covers it
  assign loadRequest = ctrlWrite && acc.wrStrb[2] && acc.wrData[vc0_ctrl_pkg::LOAD_BIT];
  assign loadFinish = (loadState_reg == vc0_ctrl_pkg::LOAD_WAIT) && tableLoadDone;

  // Load state machine and one-cycle start pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      loadState_reg <= vc0_ctrl_pkg::LOAD_IDLE;
      loadStart_reg <= 1'b0;
    end else begin
      loadStart_reg <= 1'b0;
      unique case (loadState_reg)
        vc0_ctrl_pkg::LOAD_IDLE: begin
          if (loadRequest) begin
            loadStart_reg <= 1'b1; // [R3]
            loadState_reg <= vc0_ctrl_pkg::LOAD_WAIT;
          end
        end
        vc0_ctrl_pkg::LOAD_WAIT: begin
          if (tableLoadDone) begin
            loadState_reg <= vc0_ctrl_pkg::LOAD_IDLE;
          end
        end
      endcase
    end
  end

  // Table status: a fresh entry write beats a finishing load
  always_comb begin
    tableStatus_next = tableStatus_reg;
    if (loadFinish) begin
      tableStatus_next = 1'b0; // [R9]
    end
    if (tableEntryWrite) begin
      tableStatus_next = 1'b1; // [R8]
    end
  end

  // Table status flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tableStatus_reg <= 1'b0;
    end else begin
      tableStatus_reg <= tableStatus_next;
    end
  end

  // ==========================================================
  // Negotiation tracking
  // Flag follows the negotiation engine one cycle late
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      negPending_reg <= 1'b0;
    end else begin
      negPending_reg <= negotiationBusy; // [R10]
    end
  end

  assign negComplete = negPending_reg && !negotiationBusy;

  // ==========================================================
  // Interrupts: sticky status, set wins over a write-one clear
  assign irqEvents[vc0_ctrl_pkg::IRQ_LOAD_DONE] = loadFinish;
  assign irqEvents[vc0_ctrl_pkg::IRQ_NEG_DONE] = negComplete;
  assign irqEvents[vc0_ctrl_pkg::IRQ_TABLE_WR] = tableEntryWrite;

  // Next interrupt status
  always_comb begin
    irqStatus_next = irqStatus_reg;
    if (acc.wrEn && (acc.wrAddr == vc0_ctrl_pkg::IRQ_STAT_OFFSET)) begin
      irqStatus_next = irqStatus_reg & ~lowField(acc.wrData, acc.wrStrb);
    end
    irqStatus_next = irqStatus_next | irqEvents;
  end

  // Interrupt status and mask registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqStatus_reg <= '0;
      irqMask_reg <= vc0_ctrl_pkg::IRQ_MASK_RESET;
    end else begin
      irqStatus_reg <= irqStatus_next;
      if (acc.wrEn && (acc.wrAddr == vc0_ctrl_pkg::IRQ_MASK_OFFSET) && acc.wrStrb[0]) begin
        irqMask_reg <= acc.wrData[vc0_ctrl_pkg::IRQ_WIDTH-1:0];
      end
    end
  end

  assign irq = |(irqStatus_reg & irqMask_reg);

  // ==========================================================
  // Read mux; unlisted bits stay zero
  always_comb begin
    acc.rdData = 32'h00000000; // [R12]
    acc.rdHit = 1'b1;
    unique case (acc.rdAddr)
      vc0_ctrl_pkg::CAP_OFFSET: begin
        acc.rdData[vc0_ctrl_pkg::TABLE_OFS_LSB +: 8] = vc0_ctrl_pkg::TABLE_OFS_RESET; // [R11]
      end
      vc0_ctrl_pkg::CTRL_OFFSET: begin
        acc.rdData[vc0_ctrl_pkg::MAP_LSB +: 8] = map_reg;
        acc.rdData[vc0_ctrl_pkg::LOAD_BIT] = 1'b0; // [R4]
        acc.rdData[vc0_ctrl_pkg::SEL_LSB +: 3] = select_reg;
        acc.rdData[vc0_ctrl_pkg::ID_LSB +: 3] = vc0_ctrl_pkg::CHANNEL_ID; // [R6]
        acc.rdData[vc0_ctrl_pkg::ENABLE_BIT] = enable_reg;
      end
      vc0_ctrl_pkg::STAT_OFFSET: begin
        acc.rdData[vc0_ctrl_pkg::TABLE_STAT_BIT] = tableStatus_reg;
        acc.rdData[vc0_ctrl_pkg::NEG_PEND_BIT] = negPending_reg; // [R10]
      end
      vc0_ctrl_pkg::IRQ_STAT_OFFSET: begin
        acc.rdData[vc0_ctrl_pkg::IRQ_WIDTH-1:0] = irqStatus_reg;
      end
      vc0_ctrl_pkg::IRQ_MASK_OFFSET: begin
        acc.rdData[vc0_ctrl_pkg::IRQ_WIDTH-1:0] = irqMask_reg;
      end
      default: begin
        acc.rdHit = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign classToChannelMap = map_reg;
  assign arbSchemeSelect = select_reg;
  assign channelEnable = enable_reg;
  assign tableLoadStart = loadStart_reg;

  // ==========================================================
  // Checks
  map_reset_a: assert property ( // [R1]
    @(posedge ref_clk) rst |=> (classToChannelMap == vc0_ctrl_pkg::MAP_RESET))
    else $error("map not all ones after reset");

  eeprom_load_a: assert property ( // [R2]
    @(posedge ref_clk) disable iff (rst)
    (eepromMapValid && !(ctrlWrite && acc.wrStrb[0]))
    |=> (classToChannelMap == $past(eepromMapData)))
    else $error("autoload value not taken into map");

  load_pulse_a: assert property ( // [R3]
    @(posedge ref_clk) disable iff (rst)
    (loadRequest && (loadState_reg == vc0_ctrl_pkg::LOAD_IDLE))
    |=> tableLoadStart ##1 !tableLoadStart)
    else $error("load request did not give one start pulse");

  load_reads_zero_a: assert property ( // [R4]
    @(posedge ref_clk) disable iff (rst)
    (arvalid && arready && (araddr == vc0_ctrl_pkg::CTRL_OFFSET))
    |=> !rdata[vc0_ctrl_pkg::LOAD_BIT])
    else $error("load bit read back as one");

  scheme_legal_a: assert property ( // [R5]
    @(posedge ref_clk) disable iff (rst)
    ctrlWrite && acc.wrStrb[2] && (acc.wrData[vc0_ctrl_pkg::SEL_LSB +: 3] != 3'h3)
    |=> (arbSchemeSelect == vc0_ctrl_pkg::SEL_RESET))
    else $error("illegal scheme code not forced to default");

  channel_id_a: assert property ( // [R6]
    @(posedge ref_clk) disable iff (rst)
    (arvalid && arready && (araddr == vc0_ctrl_pkg::CTRL_OFFSET))
    |=> (rdata[vc0_ctrl_pkg::ID_LSB +: 3] == 3'h0) && rvalid)
    else $error("channel identifier not zero");

  enable_write_a: assert property ( // [R7]
    @(posedge ref_clk) disable iff (rst)
    (ctrlWrite && acc.wrStrb[3])
    |=> (channelEnable == $past(acc.wrData[vc0_ctrl_pkg::ENABLE_BIT])))
    else $error("enable bit not written");

  table_set_a: assert property ( // [R8]
    @(posedge ref_clk) disable iff (rst)
    tableEntryWrite |=> tableStatus_reg)
    else $error("table write did not set status");

  table_hold_a: assert property ( // [R9]
    @(posedge ref_clk) disable iff (rst)
    (tableStatus_reg && !(loadState_reg == vc0_ctrl_pkg::LOAD_WAIT && tableLoadDone))
    |=> tableStatus_reg)
    else $error("table status cleared without finished load");

  neg_done_a: assert property ( // [R10]
    @(posedge ref_clk) disable iff (rst)
    (negotiationBusy ##1 !negotiationBusy)
    |=> !negPending_reg && irqStatus_reg[vc0_ctrl_pkg::IRQ_NEG_DONE])
    else $error("negotiation end not reflected");

  table_offset_a: assert property ( // [R11]
    @(posedge ref_clk) disable iff (rst)
    (arvalid && arready && (araddr == vc0_ctrl_pkg::CAP_OFFSET))
    |=> (rdata[31:24] == 8'h04))
    else $error("table offset not 04h");

  reserved_zero_a: assert property ( // [R12]
    @(posedge ref_clk) disable iff (rst)
    (arvalid && arready && (araddr == vc0_ctrl_pkg::STAT_OFFSET))
    |=> (rdata[15:0] == 16'h0000) && (rdata[31:18] == 14'h0000))
    else $error("reserved status bits not zero");
endmodule

// ==== tb/vc0_resource_control_status_tb.sv ====
// Self-checking bench for the channel 0 resource control and status bank
`timescale 1ns/1ps
module vc0_resource_control_status_tb;
  // ==========================================================
  // Stimulus and observed signals
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic eepromMapValid = 1'h0, tableEntryWrite = 1'h0, tableLoadDone = 1'h0;
  logic negotiationBusy = 1'h0;
  logic [7:0] eepromMapData = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, channelEnable, tableLoadStart, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0] rs;
  logic [7:0] classToChannelMap;
  logic [2:0] arbSchemeSelect;
  int bad_count = 0;
  int cmp_count = 0;
  int startCount = 0;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // Load pulses last one cycle, so they are counted at every edge
  always @(posedge ref_clk) begin
    if (tableLoadStart === 1'h1) begin
      startCount++;
    end
  end

  vc0_resource_control_status u_vc0_resource_control_status (
    .ref_clk(ref_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .eepromMapValid(eepromMapValid), .eepromMapData(eepromMapData),
    .tableEntryWrite(tableEntryWrite), .tableLoadDone(tableLoadDone),
    .negotiationBusy(negotiationBusy), .classToChannelMap(classToChannelMap),
    .arbSchemeSelect(arbSchemeSelect), .channelEnable(channelEnable),
    .tableLoadStart(tableLoadStart), .irq(irq)
  );

  // ==========================================================
  // Helpers
  // Enable, scheme and map outputs packed into one word
  function automatic logic [31:0] outs();
    return {20'h00000, channelEnable, arbSchemeSelect, classToChannelMap};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic timeout();
    bad_count++;
    $display("[FAIL] t=%0t seen=%h exp=%h bus wait ran out", $time, 1'h0, 1'h1);
    end_sim();
  endtask

  // AXI4-Lite write; the leading edge keeps two calls from driving in one step
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    int n;
    aw = 1'h1;
    w = 1'h1;
    b = 1'h0;
    n = 0;
    r = 2'h0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!b && n < 50) begin
      @(posedge ref_clk);
      n++;
      if (bvalid === 1'h1 && !aw && !w) begin
        r = bresp;
        bready <= 1'h0;
        b = 1'h1;
      end
      if (aw && awready === 1'h1) begin
        awvalid <= 1'h0;
        aw = 1'h0;
      end
      if (w && wready === 1'h1) begin
        wvalid <= 1'h0;
        w = 1'h0;
      end
    end
    if (!b) begin
      timeout();
    end
  endtask

  // AXI4-Lite read
  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, b;
    int n;
    ar = 1'h1;
    b = 1'h0;
    n = 0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!b && n < 50) begin
      @(posedge ref_clk);
      n++;
      if (rvalid === 1'h1 && !ar) begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        b = 1'h1;
      end
      if (ar && arready === 1'h1) begin
        arvalid <= 1'h0;
        ar = 1'h0;
      end
    end
    if (!b) begin
      timeout();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'h0;
    // Reset values
    check(outs(), 32'h000008FF);
    rdr(vc0_ctrl_pkg::CTRL_OFFSET, rd, rs);
    check(rd, 32'h800000FF);
    rdr(vc0_ctrl_pkg::CAP_OFFSET, rd, rs);
    check(rd, 32'h04000000);
    rdr(vc0_ctrl_pkg::STAT_OFFSET, rd, rs);
    check(rd, 32'h00000000);
    rdr(vc0_ctrl_pkg::IRQ_MASK_OFFSET, rd, rs);
    check(rd, 32'h00000000);
    $display("test reset done");
    // Ones into reserved and read-only places, channel disabled
    wr(vc0_ctrl_pkg::CTRL_OFFSET, 32'h7FF6FF5A, rs);
    check({30'h0, rs}, 32'h00000000);
    rdr(vc0_ctrl_pkg::CTRL_OFFSET, rd, rs);
    check(rd, 32'h0006005A);
    check(outs(), 32'h0000035A);
    // Every scheme code; only the two legal ones survive
    for (int c = 0; c < 8; c++) begin
      wr(vc0_ctrl_pkg::CTRL_OFFSET, 32'h800000FF | (32'(c) << 17), rs);
      rdr(vc0_ctrl_pkg::CTRL_OFFSET, rd, rs);
      check(rd, (c == 3) ? 32'h800600FF : 32'h800000FF);
      check(outs(), (c == 3) ? 32'h00000BFF : 32'h000008FF);
    end
    $display("test control done");
    // Table write, stray done, load request, repeated request, finish
    @(posedge ref_clk) tableEntryWrite <= 1'h1;
    @(posedge ref_clk) tableEntryWrite <= 1'h0;
    rdr(vc0_ctrl_pkg::STAT_OFFSET, rd, rs);
    check(rd, 32'h00010000);
    @(posedge ref_clk) tableLoadDone <= 1'h1;
    @(posedge ref_clk) tableLoadDone <= 1'h0;
    rdr(vc0_ctrl_pkg::STAT_OFFSET, rd, rs);
    check(rd, 32'h00010000);
    check(32'(startCount), 32'h00000000);
    wr(vc0_ctrl_pkg::CTRL_OFFSET, 32'h800100FF, rs);
    wr(vc0_ctrl_pkg::CTRL_OFFSET, 32'h800100FF, rs);
    rdr(vc0_ctrl_pkg::CTRL_OFFSET, rd, rs);
    check(rd, 32'h800000FF);
    check(32'(startCount), 32'h00000001);
    rdr(vc0_ctrl_pkg::STAT_OFFSET, rd, rs);
    check(rd, 32'h00010000);
    @(posedge ref_clk) tableLoadDone <= 1'h1;
    @(posedge ref_clk) tableLoadDone <= 1'h0;
    rdr(vc0_ctrl_pkg::STAT_OFFSET, rd, rs);
    check(rd, 32'h00000000);
    $display("test table load done");
    // Negotiation in progress, then complete
    negotiationBusy <= 1'h1;
    rdr(vc0_ctrl_pkg::STAT_OFFSET, rd, rs);
    check(rd, 32'h00020000);
    negotiationBusy <= 1'h0;
    rdr(vc0_ctrl_pkg::STAT_OFFSET, rd, rs);
    check(rd, 32'h00000000);
    // Autoload replaces the map
    eepromMapValid <= 1'h1;
    eepromMapData <= 8'hC3;
    @(posedge ref_clk) eepromMapValid <= 1'h0;
    @(posedge ref_clk);
    check(outs(), 32'h000008C3);
    rdr(vc0_ctrl_pkg::CTRL_OFFSET, rd, rs);
    check(rd, 32'h800000C3);
    $display("test status done");
    // Sticky events, mask, write-one clear
    rdr(vc0_ctrl_pkg::IRQ_STAT_OFFSET, rd, rs);
    check(rd, 32'h00000007);
    check({31'h0, irq}, 32'h00000000);
    wr(vc0_ctrl_pkg::IRQ_MASK_OFFSET, 32'h00000002, rs);
    check({31'h0, irq}, 32'h00000001);
    wr(vc0_ctrl_pkg::IRQ_STAT_OFFSET, 32'h00000002, rs);
    rdr(vc0_ctrl_pkg::IRQ_STAT_OFFSET, rd, rs);
    check(rd, 32'h00000005);
    check({31'h0, irq}, 32'h00000000);
    $display("test interrupt done");
    // Unmapped place and read-only status
    wr(12'h1F0, 32'hFFFFFFFF, rs);
    check({30'h0, rs}, 32'h00000003);
    rdr(12'h1F0, rd, rs);
    check(rd, 32'h00000000);
    check({30'h0, rs}, 32'h00000003);
    wr(vc0_ctrl_pkg::STAT_OFFSET, 32'hFFFFFFFF, rs);
    rdr(vc0_ctrl_pkg::STAT_OFFSET, rd, rs);
    check(rd, 32'h00000000);
    // Lane 0 alone moves only the map; the load bit needs lane 2
    wstrb <= 4'h1;
    wr(vc0_ctrl_pkg::CTRL_OFFSET, 32'h7FFFFF3C, rs);
    wstrb <= 4'hF;
    rdr(vc0_ctrl_pkg::CTRL_OFFSET, rd, rs);
    check(rd, 32'h8000003C);
    check(32'(startCount), 32'h00000001);
    $display("test decode done");
    end_sim();
  end
endmodule
